// [src/comparator_reference_control.sv]
// APB register slave and control outputs of the comparator reference.
// Assumes APB master on pclk; analog ladder and pin pad sit outside.
`timescale 1ns/1ns
module comparator_reference_control (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    output cvr_pkg::ladder_ctrl_t      ladder_ctrl,
    output logic                       level_to_pin,
    output logic                       level_to_comparators
);

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [2:0] mode_q;
    logic       dir_q;
    logic       wr_en;
    logic       rd_en;
    logic       hit;

    // Write lands at the access edge, where the master sees pready high
    assign wr_en = psel && penable && pready && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign hit   = (paddr == cvr_pkg::ref_ctrl_offset) ||
                   (paddr == cvr_pkg::comp_mode_offset) ||
                   (paddr == cvr_pkg::pin_dir_offset);

    // Control register; no sleep path touches it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= cvr_pkg::ref_ctrl_reset;
        end else if (wr_en && paddr == cvr_pkg::ref_ctrl_offset) begin
            ctrl_q <= pwdata[7:0];
        end
    end

    // Comparator mode and pin direction copies
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= cvr_pkg::comp_mode_reset;
            dir_q  <= cvr_pkg::pin_dir_reset;
        end else if (wr_en && paddr == cvr_pkg::comp_mode_offset) begin
            mode_q <= pwdata[2:0];
        end else if (wr_en && paddr == cvr_pkg::pin_dir_offset) begin
            dir_q  <= pwdata[0];
        end
    end

    // ------------------------------------------------------------
    // APB answer, no wait state
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (rd_en && paddr == cvr_pkg::ref_ctrl_offset) begin
                prdata <= {24'h00_0000, ctrl_q};
            end else if (rd_en && paddr == cvr_pkg::comp_mode_offset) begin
                prdata <= {29'h0000_0000, mode_q};
            end else if (rd_en && paddr == cvr_pkg::pin_dir_offset) begin
                prdata <= {31'h0000_0000, dir_q};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Ladder control outputs
    // ------------------------------------------------------------
    // Registered fields, follow the stored word one edge later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ladder_ctrl          <= '0;
            level_to_pin         <= 1'b0;
            level_to_comparators <= 1'b0;
        end else begin
            ladder_ctrl.ladder_power_on      <= ctrl_q[cvr_pkg::power_bit];
            ladder_ctrl.level_pin_drive      <= ctrl_q[cvr_pkg::drive_bit];
            ladder_ctrl.ladder_range_select  <= ctrl_q[cvr_pkg::range_bit];
            ladder_ctrl.ladder_source_select <= ctrl_q[cvr_pkg::source_bit];
            ladder_ctrl.ladder_level_code    <= ctrl_q[3:0];
            level_to_pin <= ctrl_q[cvr_pkg::drive_bit] && dir_q;
            level_to_comparators <= (mode_q == cvr_pkg::comp_mode_internal);
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Access edge of a write to the control register
    sequence ctrl_write_s;
        psel && penable && pready && pwrite && paddr == cvr_pkg::ref_ctrl_offset;
    endsequence

    // Setup edge of any transfer
    sequence apb_setup_s;
        psel && !penable;
    endsequence

    // Access edge of a write to an unmapped address
    sequence stray_write_s;
        psel && penable && pready && pwrite && !hit;
    endsequence

    // Access edge of a write to the comparator mode copy
    sequence mode_write_s;
        psel && penable && pready && pwrite && paddr == cvr_pkg::comp_mode_offset;
    endsequence

    // Access edge of a write to the pin direction copy
    sequence dir_write_s;
        psel && penable && pready && pwrite && paddr == cvr_pkg::pin_dir_offset;
    endsequence

    chk_ctrl_reaches_ladder: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_write_s |=> ##1 (ladder_ctrl == $past(pwdata[7:0], 2)))
        else $error("ladder control did not follow write");
    chk_power_follows_bit: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ladder_ctrl.ladder_power_on == $past(ctrl_q[7]))
        else $error("power control mismatch");
    chk_pin_needs_both: assert property (@(posedge pclk) disable iff (!presetn)
        level_to_pin |-> $past(ctrl_q[6] && dir_q))
        else $error("level driven to pin without both enables");
    chk_ctrl_holds: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(wr_en && paddr == cvr_pkg::ref_ctrl_offset) |-> $stable(ctrl_q))
        else $error("control register changed without write");
    chk_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == cvr_pkg::ref_ctrl_offset) |=> prdata == {24'h00_0000, $past(ctrl_q)})
        else $error("read back mismatch");
    chk_mode_internal: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q == cvr_pkg::comp_mode_internal) [*2] |-> level_to_comparators)
        else $error("internal mode not applied");
    chk_range_field: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ladder_ctrl.ladder_range_select == $past(ctrl_q[5]))
        else $error("range select mismatch");
    chk_code_field: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ladder_ctrl.ladder_level_code == $past(ctrl_q[3:0]))
        else $error("level code mismatch");
    chk_source_field: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ladder_ctrl.ladder_source_select == $past(ctrl_q[4]))
        else $error("source select mismatch");
    chk_drive_field: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 ladder_ctrl.level_pin_drive == $past(ctrl_q[6]))
        else $error("pin drive mismatch");

    // ------------------------------------------------------------
    // Bus handshake checks
    // ------------------------------------------------------------
    // Every setup cycle is answered in the following cycle
    chk_ready_after_setup: assert property (@(posedge pclk) disable iff (!presetn)
        apb_setup_s |=> pready)
        else $error("no ready after setup");

    // Ready stands for one cycle only
    chk_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held too long");

    // Error only comes with ready
    chk_err_with_ready: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error without ready");

    // Unmapped address answers with an error
    chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !hit) |=> pslverr)
        else $error("unmapped access without error");

    // Mapped address answers without an error
    chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && hit) |=> !pslverr)
        else $error("mapped access flagged as error");

    // ------------------------------------------------------------
    // Register update checks
    // ------------------------------------------------------------
    // Write data lands in the control register at the access edge
    chk_write_lands: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_write_s |=> ctrl_q == $past(pwdata[7:0]))
        else $error("control write did not land");

    // Stray writes leave every register alone
    chk_stray_ignored: assert property (@(posedge pclk) disable iff (!presetn)
        stray_write_s |=> $stable(ctrl_q) && $stable(mode_q) && $stable(dir_q))
        else $error("unmapped write changed a register");

    // Mode copy takes the low three bits
    chk_mode_write: assert property (@(posedge pclk) disable iff (!presetn)
        mode_write_s |=> mode_q == $past(pwdata[2:0]))
        else $error("mode write did not land");

    // Direction copy takes bit zero
    chk_dir_write: assert property (@(posedge pclk) disable iff (!presetn)
        dir_write_s |=> dir_q == $past(pwdata[0]))
        else $error("direction write did not land");

    // ------------------------------------------------------------
    // Read data and output checks
    // ------------------------------------------------------------
    // Read data is zero outside the answer to a read
    chk_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(rd_en) |-> prdata == 32'h0000_0000)
        else $error("read data not zero when idle");

    // Bits above the register width always read zero
    chk_prdata_upper: assert property (@(posedge pclk) disable iff (!presetn)
        prdata[31:8] == 24'h00_0000)
        else $error("upper read data bits set");

    // Pin level never without the drive field
    chk_pin_has_drive: assert property (@(posedge pclk) disable iff (!presetn)
        level_to_pin |-> ladder_ctrl.level_pin_drive)
        else $error("pin level without drive field");

    // Other modes keep the level off the comparators
    chk_mode_other: assert property (@(posedge pclk) disable iff (!presetn)
        (mode_q != cvr_pkg::comp_mode_internal) [*2] |-> !level_to_comparators)
        else $error("level applied in other mode");

endmodule : comparator_reference_control

// [src/cvr_pkg.sv]
// Constants and types for the comparator reference control block.
// Assumes an APB slave context on a single clock, pclk.
package cvr_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [11:0] ref_ctrl_offset    = 12'h000;
    localparam logic [11:0] comp_mode_offset   = 12'h004;
    localparam logic [11:0] pin_dir_offset     = 12'h008;
    localparam logic [7:0]  ref_ctrl_reset     = 8'h00;
    localparam logic [2:0]  comp_mode_reset    = 3'h0;
    localparam logic        pin_dir_reset      = 1'b1;
    localparam logic [2:0]  comp_mode_internal = 3'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int power_bit  = 7;
    localparam int drive_bit  = 6;
    localparam int range_bit  = 5;
    localparam int source_bit = 4;

    // Control word to the analog ladder
    typedef struct packed {
        logic       ladder_power_on;
        logic       level_pin_drive;
        logic       ladder_range_select;
        logic       ladder_source_select;
        logic [3:0] ladder_level_code;
    } ladder_ctrl_t;

endpackage : cvr_pkg

// [tb/comparator_reference_control_tb.sv]
// Self-checking bench for the comparator reference control block.
// Assumes an APB slave answering one access cycle after setup.
`timescale 1ns/1ns
module comparator_reference_control_tb;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic prdata_err, pready, pslverr, level_to_pin, level_to_comparators, pin_on;
    logic [31:0] prdata;
    logic [7:0] level_96;
    cvr_pkg::ladder_ctrl_t ladder_ctrl;
    int errors = 0, checks_done = 0;
    comparator_reference_control u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ladder_ctrl(ladder_ctrl),
        .level_to_pin(level_to_pin), .level_to_comparators(level_to_comparators));
    ladder_model u_ladder (.ladder_ctrl(ladder_ctrl), .level_to_pin(level_to_pin),
        .level_96(level_96), .pin_level_on(pin_on));
    // Clock and watchdog
    always #2 pclk = ~pclk;
    initial begin
        #40000;
        errors++;
        end_sim();
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer, then two edges so registered outputs settle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) errors++;
        rd = prdata;
        prdata_err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : apb
    task automatic t_reset_values();
        apb(1'b0, 12'h000, 32'h0); chk(rd, 32'h0);
        apb(1'b0, 12'h008, 32'h0); chk(rd, 32'h1);
        chk(32'(ladder_ctrl), 32'h0);
    endtask : t_reset_values
    task automatic t_fields();
        logic [7:0] v [6] = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h0f, 8'hff};
        // Source writes assume converter reference config already set
        foreach (v[i]) begin
            apb(1'b1, 12'h000, {24'hffffff, v[i]});
            chk(32'(ladder_ctrl), 32'(v[i]));
            apb(1'b0, 12'h000, 32'h0); chk(rd, 32'(v[i]));
        end
        apb(1'b1, 12'h000, 32'haf); chk(32'(level_96), 32'd60);
        apb(1'b1, 12'h000, 32'h8f); chk(32'(level_96), 32'd69);
    endtask : t_fields
    task automatic t_pin();
        apb(1'b1, 12'h000, 32'hc0); chk(32'(level_to_pin), 32'h1);
        chk(32'(pin_on), 32'h1);
        apb(1'b1, 12'h008, 32'h0); chk(32'(level_to_pin), 32'h0);
        apb(1'b1, 12'h008, 32'h1); apb(1'b1, 12'h000, 32'h80);
        chk(32'(level_to_pin), 32'h0);
    endtask : t_pin
    task automatic t_modes();
        for (int m = 0; m < 8; m++) begin
            apb(1'b1, 12'h004, 32'(m));
            chk(32'(level_to_comparators), 32'(m == 6));
        end
    endtask : t_modes
    task automatic t_unmapped_hold();
        apb(1'b1, 12'h00c, 32'h55); chk(32'(prdata_err), 32'h1);
        apb(1'b0, 12'h00c, 32'h0); chk(rd, 32'h0);
        repeat (20) @(posedge pclk); // Settling wait
        chk(32'(ladder_ctrl), 32'h80);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'(ladder_ctrl), 32'h0);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
    endtask : t_unmapped_hold
    task automatic end_sim();
        $display("checks_done=%0d errors=%0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_sim
    // Main sequence
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_values();
        t_fields();
        t_pin();
        t_modes();
        t_unmapped_hold();
        end_sim();
    end
endmodule : comparator_reference_control_tb

// [tb/ladder_model.sv]
// Behavioural model of the analog ladder that the control word feeds.
// Assumes the ladder_ctrl word and pin level of the reference control block.
`timescale 1ns/1ns
module ladder_model (
    input  wire cvr_pkg::ladder_ctrl_t ladder_ctrl,
    input  wire logic                  level_to_pin,
    output logic [7:0]                 level_96,
    output logic                       pin_level_on
);
    // Output level in 1/96 units of the selected source span
    always_comb begin
        if (!ladder_ctrl.ladder_power_on) begin
            level_96 = 8'h00;
        end else if (ladder_ctrl.ladder_range_select) begin
            level_96 = {2'h0, ladder_ctrl.ladder_level_code, 2'h0};
        end else begin
            level_96 = 8'h18 + 8'(ladder_ctrl.ladder_level_code) * 8'h03;
        end
    end
    assign pin_level_on = level_to_pin & ladder_ctrl.ladder_power_on;
endmodule : ladder_model
